/* File: verilog/pdr_pkg.sv */
/*
 * Shared constants and types for the port detection result block:
 * command codes of the resistance registers, widths, reset values,
 * clock and timing figures, and the per-port power sequencing states.
 * Assumes a single 10 MHz controller clock.
 */
package pdr_pkg;

    // -------------------------------------------------------------
    // register map (command codes)
    // -------------------------------------------------------------
    localparam logic [7:0] CMD_RES_PORT1 = 8'h44;
    localparam logic [7:0] CMD_RES_PORT2 = 8'h45;
    localparam logic [7:0] CMD_RES_PORT3 = 8'h46;
    localparam logic [7:0] CMD_RES_PORT4 = 8'h47;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    // -------------------------------------------------------------
    // fields and reset values
    // -------------------------------------------------------------
    localparam int NUM_PORTS = 4;
    localparam int RES_W = 8;
    localparam int RES_MSB = 7;
    localparam int RES_LSB = 0;
    localparam logic [7:0] RES_RST = 8'h00;
    // ohms per count; the printed value is absent, plain default
    localparam int RES_STEP_OHM = 256;

    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
    localparam int COOL_MS = 1000;
    localparam int COOL_W = 16;

    // -------------------------------------------------------------
    // port power sequencing
    // -------------------------------------------------------------
    typedef enum logic [1:0] {
        PS_OFF  = 2'b00,
        PS_ON   = 2'b01,
        PS_COOL = 2'b10
    } pdr_state_t;

endpackage

/* File: verilog/pdr_tick_div.sv */
/*
 * Divider that turns the controller clock into a one-cycle
 * millisecond enable pulse for the cool-down timers.
 * Assumes a synchronous active-high reset on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module pdr_tick_div
    import pdr_pkg::*;
#(
    parameter int DIV = TICK_CYC
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    output logic o_tick
);

    if (DIV < 2 || DIV > 65536)
    begin : g_bad_div
        $error("divider ratio out of range");
    end

    logic [15:0] cnt_r;

    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b0;
        end
        else if (cnt_r == 16'(DIV - 1))
        begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
            o_tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/pdr_port_seq.sv */
/*
 * Power-down and detection-restart sequencer of one port: powers the
 * port off on command, disconnect or fault, runs the cool-down after a
 * fault and restarts detection or classification at its end.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module pdr_port_seq
    import pdr_pkg::*;
#(
    parameter int COOL_TICKS = COOL_MS
)
(
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_tick,
    input wire logic i_pwr_on,
    input wire logic i_pwr_off,
    input wire logic i_disconnect,
    input wire logic i_fault,
    input wire logic i_det_en,
    input wire logic i_cls_en,
    input wire logic i_detcls_cmd,
    output logic o_power,
    output logic o_cool,
    output logic o_det_start,
    output logic o_cls_start
);

    if (COOL_TICKS < 1 || COOL_TICKS >= (1 << COOL_W))
    begin : g_bad_cool
        $error("cool-down length out of range");
    end

    pdr_state_t state_r;
    logic [COOL_W-1:0] cool_cnt_r;
    logic cool_end;

    assign cool_end = (state_r == PS_COOL) && i_tick
        && (cool_cnt_r == COOL_W'(1));
    assign o_power = (state_r == PS_ON);
    assign o_cool = (state_r == PS_COOL);

    // -------------------------------------------------------------
    // power state
    // -------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_r <= PS_OFF;
        end
        else
        begin
            case (state_r)
                PS_OFF:
                begin
                    if (i_pwr_on)
                    begin
                        state_r <= PS_ON;
                    end
                end
                PS_ON:
                begin
                    // fault wins: it must also start the cool-down
                    if (i_fault)
                    begin
                        state_r <= PS_COOL;
                    end
                    else if (i_pwr_off || i_disconnect)
                    begin
                        state_r <= PS_OFF;
                    end
                end
                PS_COOL:
                begin
                    if (cool_end)
                    begin
                        state_r <= PS_OFF;
                    end
                end
                default:
                begin
                    state_r <= PS_OFF;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // cool-down timer, in millisecond ticks
    // -------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            cool_cnt_r <= '0;
        end
        else if (state_r == PS_ON && i_fault)
        begin
            cool_cnt_r <= COOL_W'(COOL_TICKS);
        end
        else if (state_r == PS_COOL && i_tick)
        begin
            cool_cnt_r <= cool_cnt_r - COOL_W'(1);
        end
    end

    // -------------------------------------------------------------
    // detection / classification starts
    // -------------------------------------------------------------
    // a command seen during cool-down is dropped, but the end of cool-down
    // starts whatever the enable bits then ask for, with or without one
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            o_det_start <= 1'b0;
            o_cls_start <= 1'b0;
        end
        else if (cool_end)
        begin
            o_det_start <= i_det_en;
            o_cls_start <= i_cls_en;
        end
        else if (state_r == PS_OFF && i_detcls_cmd)
        begin
            o_det_start <= i_det_en;
            o_cls_start <= i_cls_en;
        end
        else
        begin
            o_det_start <= 1'b0;
            o_cls_start <= 1'b0;
        end
    end

endmodule

`default_nettype wire

/* File: verilog/pdr_detect_result_regs.sv */
/*
 * Detection resistance result registers of ports 1 to 4, read by the
 * host through the controller's command-code register access, plus the
 * per-port power-down and detection-restart sequencing.
 * Assumes the command interface, measurement results and port events
 * come from logic on I_REF_CLK; no synchronisers are needed.
 */
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - four read-only byte registers at codes 44h to 47h, zero after reset
// - each register holds its own port's 8-bit result in bits 7 to 0
// - each finished two-point measurement overwrites that port's register
// - switching a port off leaves its stored count untouched
// - resistance is the stored count times a fixed step
// - port loses power on off command, disconnect, or fault
// - after off command or disconnect, restart waits for a host request
// - after a fault, cool-down holds off detect and class commands
// - cool-down end auto-starts detection or class when enabled
module pdr_detect_result_regs
    import pdr_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC,
    parameter int COOL_TICKS = COOL_MS
)
(
    input wire logic I_REF_CLK,
    input wire logic I_SRST,
    input wire logic [NUM_PORTS-1:0] I_MEAS_DONE,
    input wire logic [NUM_PORTS*RES_W-1:0] I_MEAS_COUNT,
    input wire logic I_CMD_VALID,
    input wire logic I_CMD_WRITE,
    input wire logic [7:0] I_CMD_CODE,
    input wire logic [7:0] I_CMD_WDATA,
    output logic [7:0] O_RD_DATA,
    output logic O_RD_HIT,
    input wire logic [NUM_PORTS-1:0] I_PWR_ON_CMD,
    input wire logic [NUM_PORTS-1:0] I_PWR_OFF_CMD,
    input wire logic [NUM_PORTS-1:0] I_DISCONNECT,
    input wire logic [NUM_PORTS-1:0] I_START_FAULT,
    input wire logic [NUM_PORTS-1:0] I_CUTOFF_FAULT,
    input wire logic [NUM_PORTS-1:0] I_LIMIT_FAULT,
    input wire logic [NUM_PORTS-1:0] I_DET_EN,
    input wire logic [NUM_PORTS-1:0] I_CLS_EN,
    input wire logic [NUM_PORTS-1:0] I_DETCLS_CMD,
    output logic [NUM_PORTS-1:0] O_PORT_POWER,
    output logic [NUM_PORTS-1:0] O_COOLDOWN,
    output logic [NUM_PORTS-1:0] O_DET_START,
    output logic [NUM_PORTS-1:0] O_CLS_START
);

    if (NUM_PORTS != 4 || RES_W != 8)
    begin : g_bad_map
        $error("register map serves four byte-wide ports only");
    end

    // -------------------------------------------------------------
    // storage
    // -------------------------------------------------------------
    logic [RES_W-1:0] res_r [NUM_PORTS];
    logic tick;
    logic rd_req;
    logic wr_req;
    logic [7:0] rd_nxt;
    logic hit_nxt;

    // resistance in ohms is res_r times RES_STEP_OHM; kept as a count
    // so software scales it and no multiplier sits in the fabric
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_res
        always_ff @(posedge I_REF_CLK)
        begin
            if (I_SRST)
            begin
                res_r[p] <= RES_RST;
            end
            else if (I_MEAS_DONE[p])
            begin
                // only the measurement path writes here, and power-down
                // has no clearing path
                res_r[p] <= I_MEAS_COUNT[p*RES_W +: RES_W];
            end
        end
    end

    // -------------------------------------------------------------
    // command-code read access
    // -------------------------------------------------------------
    assign rd_req = I_CMD_VALID && !I_CMD_WRITE;
    // writes are decoded only to be dropped; the registers have no
    // write path, so the data byte is never looked at
    assign wr_req = I_CMD_VALID && I_CMD_WRITE;

    always_comb
    begin
        rd_nxt = RD_UNMAPPED;
        hit_nxt = 1'b1;
        case (I_CMD_CODE)
            CMD_RES_PORT1: rd_nxt = res_r[0];
            CMD_RES_PORT2: rd_nxt = res_r[1];
            CMD_RES_PORT3: rd_nxt = res_r[2];
            CMD_RES_PORT4: rd_nxt = res_r[3];
            default: hit_nxt = 1'b0;
        endcase
    end

    // read answer stands until the next read request
    always_ff @(posedge I_REF_CLK)
    begin
        if (I_SRST)
        begin
            O_RD_DATA <= RD_UNMAPPED;
            O_RD_HIT <= 1'b0;
        end
        else if (rd_req)
        begin
            O_RD_DATA <= rd_nxt;
            O_RD_HIT <= hit_nxt;
        end
    end

    // -------------------------------------------------------------
    // power sequencing
    // -------------------------------------------------------------
    pdr_tick_div #(
        .DIV(TICK_CYCLES)
    ) u_tick (
        .i_clk(I_REF_CLK),
        .i_srst(I_SRST),
        .o_tick(tick)
    );

    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        pdr_port_seq #(
            .COOL_TICKS(COOL_TICKS)
        ) u_seq (
            .i_clk(I_REF_CLK),
            .i_srst(I_SRST),
            .i_tick(tick),
            .i_pwr_on(I_PWR_ON_CMD[p]),
            .i_pwr_off(I_PWR_OFF_CMD[p]),
            .i_disconnect(I_DISCONNECT[p]),
            .i_fault(I_START_FAULT[p] || I_CUTOFF_FAULT[p]
                || I_LIMIT_FAULT[p]),
            .i_det_en(I_DET_EN[p]),
            .i_cls_en(I_CLS_EN[p]),
            .i_detcls_cmd(I_DETCLS_CMD[p]),
            .o_power(O_PORT_POWER[p]),
            .o_cool(O_COOLDOWN[p]),
            .o_det_start(O_DET_START[p]),
            .o_cls_start(O_CLS_START[p])
        );
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (I_SRST);

    property p_reset_zero;
        $past(I_SRST) && !I_MEAS_DONE[3] |-> res_r[3] == RES_RST;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("result register not zero after reset");

    property p_read_port1;
        rd_req && I_CMD_CODE == CMD_RES_PORT1 && !I_MEAS_DONE[0]
            |=> O_RD_HIT && O_RD_DATA == res_r[0];
    endproperty
    a_read_port1: assert property (p_read_port1)
        else $error("port 1 read returned wrong byte");

    property p_read_unmapped;
        rd_req && (I_CMD_CODE < CMD_RES_PORT1 || I_CMD_CODE > CMD_RES_PORT4)
            |=> !O_RD_HIT && O_RD_DATA == RD_UNMAPPED;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped code answered as a hit");

    property p_store_own;
        I_MEAS_DONE[2] && !I_MEAS_DONE[1]
            |=> res_r[2] == $past(I_MEAS_COUNT[2*RES_W +: RES_W])
            && $stable(res_r[1]);
    endproperty
    a_store_own: assert property (p_store_own)
        else $error("measurement not stored in its own port");

    property p_keep_at_off;
        !I_MEAS_DONE[0] ##1 $fell(O_PORT_POWER[0]) && !I_MEAS_DONE[0]
            |=> res_r[0] == $past(res_r[0], 2);
    endproperty
    a_keep_at_off: assert property (p_keep_at_off)
        else $error("stored count changed at port turn-off");

    property p_write_ignored;
        wr_req && I_CMD_CODE == CMD_RES_PORT2 && !I_MEAS_DONE[1]
            && I_CMD_WDATA != res_r[1] |=> $stable(res_r[1]);
    endproperty
    a_write_ignored: assert property (p_write_ignored)
        else $error("host write altered a result register");

    property p_off_cmd;
        O_PORT_POWER[3] && I_PWR_OFF_CMD[3] && !I_START_FAULT[3]
            && !I_CUTOFF_FAULT[3] && !I_LIMIT_FAULT[3]
            |=> !O_PORT_POWER[3] && !O_COOLDOWN[3];
    endproperty
    a_off_cmd: assert property (p_off_cmd)
        else $error("port still powered after off command");

    property p_fault_cool;
        O_PORT_POWER[0]
            && (I_START_FAULT[0] || I_CUTOFF_FAULT[0] || I_LIMIT_FAULT[0])
            |=> !O_PORT_POWER[0] && O_COOLDOWN[0];
    endproperty
    a_fault_cool: assert property (p_fault_cool)
        else $error("fault did not start cool-down");

    property p_hold_in_cool;
        O_COOLDOWN[0] |-> !O_DET_START[0] && !O_CLS_START[0];
    endproperty
    a_hold_in_cool: assert property (p_hold_in_cool)
        else $error("detection started during cool-down");

    property p_no_self_restart;
        !O_COOLDOWN[2] && !I_DETCLS_CMD[2] |=> !O_DET_START[2];
    endproperty
    a_no_self_restart: assert property (p_no_self_restart)
        else $error("detection restarted without host request");

    property p_cool_end_start;
        $fell(O_COOLDOWN[0]) |-> O_DET_START[0] == $past(I_DET_EN[0])
            && O_CLS_START[0] == $past(I_CLS_EN[0]);
    endproperty
    a_cool_end_start: assert property (p_cool_end_start)
        else $error("cool-down end did not restart enabled cycles");

    // -------------------------------------------------------------
    // read port and per-port sequencing checks
    // -------------------------------------------------------------
    property p_read_port4;
        rd_req && I_CMD_CODE == CMD_RES_PORT4 && !I_MEAS_DONE[3]
            |=> O_RD_HIT && O_RD_DATA == res_r[3];
    endproperty
    a_read_port4: assert property (p_read_port4)
        else $error("port 4 read returned wrong byte");

    // the answer must stand between reads so a slow host still sees it
    property p_read_holds;
        !rd_req |=> $stable(O_RD_DATA) && $stable(O_RD_HIT);
    endproperty
    a_read_holds: assert property (p_read_holds)
        else $error("read answer moved without a read");

    property p_reset_read;
        $past(I_SRST) |-> !O_RD_HIT && O_RD_DATA == RD_UNMAPPED;
    endproperty
    a_reset_read: assert property (p_reset_read)
        else $error("read answer not cleared by reset");

    property p_disc_off;
        O_PORT_POWER[3] && I_DISCONNECT[3] && !I_START_FAULT[3]
            && !I_CUTOFF_FAULT[3] && !I_LIMIT_FAULT[3]
            |=> !O_PORT_POWER[3] && !O_COOLDOWN[3];
    endproperty
    a_disc_off: assert property (p_disc_off)
        else $error("port still powered after disconnect");

    property p_cutoff_cool;
        O_PORT_POWER[1] && I_CUTOFF_FAULT[1]
            |=> !O_PORT_POWER[1] && O_COOLDOWN[1];
    endproperty
    a_cutoff_cool: assert property (p_cutoff_cool)
        else $error("cut-off fault did not start cool-down");

    property p_limit_cool;
        O_PORT_POWER[2] && I_LIMIT_FAULT[2]
            |=> !O_PORT_POWER[2] && O_COOLDOWN[2];
    endproperty
    a_limit_cool: assert property (p_limit_cool)
        else $error("current-limit fault did not start cool-down");

    property p_cmd_start;
        !O_PORT_POWER[3] && !O_COOLDOWN[3] && I_DETCLS_CMD[3]
            |=> O_DET_START[3] == $past(I_DET_EN[3])
            && O_CLS_START[3] == $past(I_CLS_EN[3]);
    endproperty
    a_cmd_start: assert property (p_cmd_start)
        else $error("host request did not restart detection");

    property p_hold_cool1;
        O_COOLDOWN[1] |-> !O_DET_START[1] && !O_CLS_START[1];
    endproperty
    a_hold_cool1: assert property (p_hold_cool1)
        else $error("port 2 started a cycle during cool-down");

    // a second pulse would run a cycle that nobody asked for
    property p_start_pulse;
        O_CLS_START[1] && !I_DETCLS_CMD[1] |=> !O_CLS_START[1];
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("class start pulse lasted more than one cycle");

endmodule

`default_nettype wire

/* File: bench/pdr_host_model.sv */
/*
 * Host-side model of the port controller's command access: single-byte
 * command-code reads and writes, and per-port detect/class requests.
 * Assumes its tasks are called by the bench between clock edges.
 */
`timescale 1ns/1ns
`default_nettype none

module pdr_host_model
    import pdr_pkg::*;
(
    input wire logic i_clk,
    output logic o_valid,
    output logic o_write,
    output logic [7:0] o_code,
    output logic [7:0] o_wdata,
    output logic [NUM_PORTS-1:0] o_detcls
);
    initial
    begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_code = 8'h00;
        o_wdata = 8'h00;
        o_detcls = 4'h0;
    end

    // ---------------------------------------------------------------
    // accesses
    // ---------------------------------------------------------------
    // outside a request code and data are inverted, so a stale sample
    // by the device never looks like a valid one
    task automatic access(input logic w, input logic [7:0] c,
                          input logic [7:0] d);
        @(posedge i_clk);
        o_valid <= 1'b1;
        o_write <= w;
        o_code <= c;
        o_wdata <= d;
        @(posedge i_clk);
        o_valid <= 1'b0;
        o_code <= ~c;
        o_wdata <= ~d;
    endtask

    // restart of detection after an off command or disconnect
    task automatic detcls(input int p);
        @(posedge i_clk);
        o_detcls[p] <= 1'b1;
        @(posedge i_clk);
        o_detcls[p] <= 1'b0;
    endtask
endmodule

`default_nettype wire

/* File: bench/pdr_detect_result_regs_tb.sv */
/*
 * Self-checking bench of the detection result registers and the port
 * power sequencing, with a host model on the command port.
 * Assumes short cool-down parameters: 4 clocks per tick, 3 ticks.
 */
`timescale 1ns/1ns
`default_nettype none

module pdr_detect_result_regs_tb;
    import pdr_pkg::*;

    logic clk;
    logic srst;
    logic [3:0] meas_done;
    logic [31:0] meas_count;
    logic [3:0] evs [6];
    logic [3:0] det_en;
    logic [3:0] cls_en;
    logic cmd_valid, cmd_write;
    logic [7:0] cmd_code, cmd_wdata;
    logic [3:0] detcls;
    logic [7:0] O_RD_DATA;
    logic O_RD_HIT;
    logic [3:0] O_PORT_POWER, O_COOLDOWN, O_DET_START, O_CLS_START;
    int err_count = 0;
    int n_tests = 0;
    int seed = 32'h2f2c_a971;
    int det_n [4];
    int cls_n [4];
    int cyc;
    logic rd_pend = 1'b0;
    logic [8:0] rd_q [$];
    logic [7:0] mv [4];

    pdr_detect_result_regs #(.TICK_CYCLES(4), .COOL_TICKS(3)) i_dut (
        .I_REF_CLK(clk), .I_SRST(srst), .I_MEAS_DONE(meas_done),
        .I_MEAS_COUNT(meas_count), .I_CMD_VALID(cmd_valid),
        .I_CMD_WRITE(cmd_write), .I_CMD_CODE(cmd_code),
        .I_CMD_WDATA(cmd_wdata), .O_RD_DATA(O_RD_DATA),
        .O_RD_HIT(O_RD_HIT), .I_PWR_ON_CMD(evs[0]),
        .I_PWR_OFF_CMD(evs[1]), .I_DISCONNECT(evs[2]),
        .I_START_FAULT(evs[3]), .I_CUTOFF_FAULT(evs[4]),
        .I_LIMIT_FAULT(evs[5]), .I_DET_EN(det_en), .I_CLS_EN(cls_en),
        .I_DETCLS_CMD(detcls), .O_PORT_POWER(O_PORT_POWER),
        .O_COOLDOWN(O_COOLDOWN), .O_DET_START(O_DET_START),
        .O_CLS_START(O_CLS_START));

    pdr_host_model i_host (
        .i_clk(clk), .o_valid(cmd_valid), .o_write(cmd_write),
        .o_code(cmd_code), .o_wdata(cmd_wdata), .o_detcls(detcls));

    // ---------------------------------------------------------------
    // compares and monitor
    // ---------------------------------------------------------------
    task automatic chk_rd(input logic [8:0] exp);
        n_tests++;
        if ({O_RD_HIT, O_RD_DATA} !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp,
                     {O_RD_HIT, O_RD_DATA});
        end
    endtask

    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // read data lands one edge after the taking edge
    always @(posedge clk)
    begin
        if (rd_pend)
            chk_rd(rd_q.pop_front());
        rd_pend <= cmd_valid && !cmd_write;
        for (int p = 0; p < 4; p++)
        begin
            det_n[p] += int'(O_DET_START[p]);
            cls_n[p] += int'(O_CLS_START[p]);
        end
    end

    task automatic rd(input logic [7:0] c, input logic [8:0] exp);
        rd_q.push_back(exp);
        i_host.access(1'b0, c, 8'h00);
    endtask

    task automatic rd_all();
        for (int p = 0; p < 4; p++)
            rd(CMD_RES_PORT1 + 8'(p), {1'b1, mv[p]});
    endtask

    task automatic ev(input int k, input int p);
        @(posedge clk);
        evs[k][p] <= 1'b1;
        @(posedge clk);
        evs[k][p] <= 1'b0;
        @(negedge clk);
    endtask

    task automatic clr();
        @(negedge clk);
        det_n = '{default: 0};
        cls_n = '{default: 0};
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #(100 * 20000);
        err_count++;
        summarize();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        srst = 1'b1;
        meas_done = 4'h0;
        meas_count = 32'h0000_0000;
        evs = '{default: 4'h0};
        det_en = 4'h0;
        cls_en = 4'h0;
        mv = '{default: 8'h00};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        rd_all();
        rd(RD_UNMAPPED, 9'h000);
        rd(8'h48, 9'h000);
        rd(8'h43, 9'h000);
        $display("test reset_values done");
        for (int p = 0; p < 4; p++)
            mv[p] = 8'($random(seed));
        @(posedge clk);
        meas_done <= 4'hF;
        meas_count <= {mv[3], mv[2], mv[1], mv[0]};
        @(posedge clk);
        meas_done <= 4'h0;
        meas_count <= ~{mv[3], mv[2], mv[1], mv[0]};
        rd_all();
        mv[2] = ~mv[2] ^ 8'h5a;
        @(posedge clk);
        meas_done <= 4'h4;
        meas_count[23:16] <= mv[2];
        @(posedge clk);
        meas_done <= 4'h0;
        rd_all();
        $display("test measurement done");
        for (int p = 0; p < 4; p++)
            i_host.access(1'b1, CMD_RES_PORT1 + 8'(p),
                          mv[p] ^ (8'($random(seed)) | 8'h01));
        rd_all();
        $display("test write_ignored done");
        det_en <= 4'b1011;
        cls_en <= 4'b0110;
        for (int k = 3; k < 6; k++)
        begin
            ev(0, k - 3);
            chk_v(8'(O_PORT_POWER[k - 3]), 8'h01);
            clr();
            ev(k, k - 3);
            chk_v(8'({O_PORT_POWER[k - 3], O_COOLDOWN[k - 3]}),
                  8'h01);
            i_host.detcls(k - 3);
            ev(0, k - 3);
            chk_v(8'(det_n[k - 3] + cls_n[k - 3]), 8'h00);
            chk_v(8'(O_PORT_POWER[k - 3]), 8'h00);
            cyc = 0;
            while (O_COOLDOWN[k - 3] === 1'b1 && cyc < 40)
            begin
                @(negedge clk);
                cyc++;
            end
            chk_v(8'(cyc < 40), 8'h01);
            @(negedge clk);
            chk_v(8'(det_n[k - 3]), 8'(det_en[k - 3]));
            chk_v(8'(cls_n[k - 3]), 8'(cls_en[k - 3]));
        end
        $display("test fault_cooldown done");
        for (int k = 1; k < 3; k++)
        begin
            ev(0, 3);
            clr();
            ev(k, 3);
            chk_v(8'({O_PORT_POWER[3], O_COOLDOWN[3]}), 8'h00);
            repeat (20) @(negedge clk);
            chk_v(8'(det_n[3] + cls_n[3]), 8'h00);
            i_host.detcls(3);
            repeat (2) @(negedge clk);
            chk_v(8'(det_n[3]), 8'(det_en[3]));
            chk_v(8'(cls_n[3]), 8'(cls_en[3]));
        end
        rd_all();
        repeat (4) @(posedge clk);
        $display("test off_restart done");
        summarize();
    end
endmodule

`default_nettype wire
